// *** verilog/calib_pkg.sv ***
// Shared constants and types for the converter core calibration controller
package calib_pkg;
    localparam int          NUM_BANKS      = 6;
    localparam int          NUM_CORES      = 3;
    localparam int          DATA_W         = 12;
    localparam logic [11:0] MID_CODE       = 12'h000;
    localparam int          TRIM_W         = 8;
    localparam int          NUM_TRIMS      = 8;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_SOFT_TRIG = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_TIMING    = 12'h00c;
    localparam logic [11:0] ADDR_TRIM_BASE = 12'h040;

    // Control register field positions
    localparam int CTRL_TRIG_SEL   = 0;
    localparam int CTRL_BG_EN      = 1;
    localparam int CTRL_FG_OS      = 2;
    localparam int CTRL_BG_OS      = 3;
    localparam int CTRL_LOW_POWER_BG_ENABLE      = 4;
    localparam int CTRL_LP_SW_SEL  = 5;
    localparam int CTRL_SINGLE_CH  = 6;
    localparam int CTRL_INPUT_B    = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Step lengths in core clock cycles
    localparam logic [15:0] CAL_STEP_CYCLES  = 16'h0100;
    localparam logic [15:0] SLEEP_RESET      = 16'h0400;
    localparam logic [15:0] WAKE_RESET       = 16'h0040;
    localparam logic [15:0] SWAP_SETTLE      = 16'h0004;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_FG_CAL  = 3'b001,
        ST_BG_SLEEP= 3'b010,
        ST_BG_WAKE = 3'b011,
        ST_BG_CAL  = 3'b100,
        ST_BG_SWAP = 3'b101
    } cal_state_t;

    // Phases of one pass over a core
    typedef enum logic [1:0] {
        PH_LIN    = 2'b00,
        PH_GAIN   = 2'b01,
        PH_OFFSET = 2'b10
    } cal_phase_t;

    typedef struct packed {
        logic [1:0] core_a_input;    // Input sampled by slot A (0 = A, 1 = B)
        logic [1:0] core_b_input;
        logic [1:0] slot_a_core;     // Physical core serving output slot A
        logic [1:0] slot_b_core;
        logic [2:0] core_power;      // One bit per core
        logic [5:0] bank_phase;      // Sampling phase per bank
    } core_map_t;
endpackage

// *** verilog/trig_edge.sv ***
// Synchroniser and rising-edge detector for a trigger level
`timescale 1ns/1ps
module trig_edge (
    input  wire logic core_clk,   // Core clock
    input  wire logic rst_n,      // Synchronous reset, active low
    input  wire logic async_in,   // Level from a pin
    input  wire logic sync_src,   // Selects the already synchronous level
    input  wire logic local_in,   // Level from same-clock logic
    output logic      rise        // One-cycle pulse on a rising edge
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    wire  level = sync_src ? local_in : sync_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
endmodule

// *** verilog/trim_bank.sv ***
// Trim value storage loaded from factory values and overridable by software
`timescale 1ns/1ps
module trim_bank #(
    parameter int N = calib_pkg::NUM_TRIMS,
    parameter int W = calib_pkg::TRIM_W
) (
    input  wire logic                 core_clk,    // Core clock
    input  wire logic                 rst_n,       // Synchronous reset, active low
    input  wire logic [N*W-1:0]       factory_val, // Fused factory trim values
    input  wire logic                 wr_en,       // Write strobe
    input  wire logic [$clog2(N)-1:0] idx,         // Entry index
    input  wire logic [W-1:0]         wr_data,     // Write data
    output logic      [W-1:0]         rd_data,     // Read data at idx
    output logic      [N*W-1:0]       trim_out     // All values to analog
);
    logic [W-1:0] trim_q [N];
    logic         load_q;

    // Fuses are captured during reset and at the first edge after release, never inside the reset branch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < N; i++) begin
            if (load_q) begin
                trim_q[i] <= factory_val[i*W +: W];
            end else if (wr_en && idx == i[$clog2(N)-1:0]) begin
                trim_q[i] <= wr_data;
            end
        end
    end

    assign rd_data = trim_q[idx];
    generate
        for (genvar g = 0; g < N; g++) begin : g_out
            assign trim_out[g*W +: W] = trim_q[g];
        end
    endgenerate
endmodule

// *** verilog/adc_core_calibration_control.sv ***
// Calibration sequencer for a three-core, six-bank converter with APB registers
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Foreground cal: cores offline, output mid-code
// - Background cal keeps data flowing via substitute
// - Six banks, pairs form three cores
// - Banks of a core sample opposite phases
// - Dual: cores take A,B; single: same input
// - Spare periodically replaces first or second core
// - Calibrate removed core, it relieves next
// - Each pass: linearity, gain, offset per bank
// - Foreground cal runs at power-up; host waits
// - Pin or soft trigger, source select chooses
// - Inputs live during cal except offset step
// - Trims load factory values, readable, writable
// - Trims grouped per input, bank, core
// - Swap glitches kept brief, permitted
// - Low-power: offline core powered down
// - Low-power: auto or triggered switching
module adc_core_calibration_control (
    input  wire logic                 core_clk,      // 50 MHz core clock
    input  wire logic                 rst_n,         // Synchronous reset, active low
    input  wire logic                 psel,          // APB select
    input  wire logic                 penable,       // APB enable
    input  wire logic                 pwrite,        // APB direction
    input  wire logic [11:0]          paddr,         // APB byte address
    input  wire logic [31:0]          pwdata,        // APB write data
    output logic      [31:0]          prdata,        // APB read data
    output logic                      pready,        // APB ready
    output logic                      pslverr,       // APB error
    input  wire logic                 hw_calib_trigger_pin, // Trigger pin
    input  wire logic [calib_pkg::NUM_TRIMS*calib_pkg::TRIM_W-1:0] factory_trim, // Fuses
    input  wire logic [calib_pkg::DATA_W-1:0] slot_a_raw, // Converted data, slot A
    input  wire logic [calib_pkg::DATA_W-1:0] slot_b_raw, // Converted data, slot B
    output logic      [calib_pkg::DATA_W-1:0] sample_a,   // Output data, slot A
    output logic      [calib_pkg::DATA_W-1:0] sample_b,   // Output data, slot B
    output calib_pkg::core_map_t      core_map,      // Core routing and power
    output logic      [2:0]           cal_core_sel,  // One-hot core under calibration
    output logic      [1:0]           cal_phase,     // Current calibration step
    output logic                      cal_ref_en,    // Internal reference enable
    output logic                      input_mute,    // Offset step needs quiet input
    output logic [calib_pkg::NUM_TRIMS*calib_pkg::TRIM_W-1:0] trim_out, // Trims
    output logic                      fg_done        // Foreground cal finished
);
    // Odd banks sample on the opposite clock phase of their partner bank
    localparam logic [5:0] BANK_PHASE = 6'h2a;
    localparam logic [1:0] LAST_CORE  = 2'(calib_pkg::NUM_CORES - 1);
    localparam int         IDX_W      = $clog2(calib_pkg::NUM_TRIMS);

    // One-hot select of a physical core, used for calibration and power
    function automatic logic [2:0] core_onehot(input logic [1:0] idx);
        core_onehot = 3'h1 << idx;
    endfunction

    function automatic logic in_cal(input calib_pkg::cal_state_t st);
        in_cal = (st == calib_pkg::ST_FG_CAL) || (st == calib_pkg::ST_BG_CAL);
    endfunction

    function automatic logic in_bg(input calib_pkg::cal_state_t st);
        in_bg = (st == calib_pkg::ST_BG_SLEEP) || (st == calib_pkg::ST_BG_WAKE) ||
                (st == calib_pkg::ST_BG_CAL) || (st == calib_pkg::ST_BG_SWAP);
    endfunction

    // Software visible registers
    logic [7:0]                     ctrl_q;
    logic                           sw_calib_trigger_bit;
    logic [15:0]                    sleep_len_q;
    logic [15:0]                    wake_len_q;
    logic [31:0]                    prdata_q;
    logic                           pready_q;
    logic                           pslverr_q;

    // Sequencer state
    calib_pkg::cal_state_t          state_q;
    calib_pkg::cal_state_t          state_d;
    calib_pkg::cal_phase_t          phase_q;
    calib_pkg::cal_phase_t          phase_d;
    logic [15:0]                    step_cnt_q;
    logic [15:0]                    step_cnt_d;
    logic [1:0]                     core_q;        // Core under calibration
    logic [1:0]                     core_d;
    logic                           bank_q;        // Bank within that core
    logic                           bank_d;
    logic [1:0]                     spare_q;       // Core currently off-line
    logic [1:0]                     spare_d;
    logic [1:0]                     slot_a_q;
    logic [1:0]                     slot_a_d;
    logic [1:0]                     slot_b_q;
    logic [1:0]                     slot_b_d;
    logic                           victim_q;      // Slot relieved next: 0 = A, 1 = B
    logic                           victim_d;
    logic                           fg_done_q;

    // Output flops
    logic [calib_pkg::DATA_W-1:0]   sample_a_q;
    logic [calib_pkg::DATA_W-1:0]   sample_b_q;
    calib_pkg::core_map_t           core_map_q;
    calib_pkg::core_map_t           map_d;
    logic [2:0]                     cal_core_sel_q;
    logic                           cal_ref_en_q;
    logic                           input_mute_q;
    logic [calib_pkg::TRIM_W-1:0]   trim_rd;
    logic                           trig_rise;

    // Bus decode: one wait state, the answer stands at the second access edge
    wire apb_access = psel & penable & ~pready_q;
    wire apb_commit = psel & penable & pready_q;
    wire wr_commit  = apb_commit & pwrite;
    wire hit_ctrl   = (paddr == calib_pkg::ADDR_CTRL);
    wire hit_soft   = (paddr == calib_pkg::ADDR_SOFT_TRIG);
    wire hit_status = (paddr == calib_pkg::ADDR_STATUS);
    wire hit_timing = (paddr == calib_pkg::ADDR_TIMING);
    wire hit_trim   = (paddr[11:5] == calib_pkg::ADDR_TRIM_BASE[11:5]) &&
                      (paddr[1:0] == 2'b00);
    wire hit_any    = hit_ctrl | hit_soft | hit_status | hit_timing | hit_trim;
    wire trim_wr    = wr_commit & hit_trim;
    wire [IDX_W-1:0] trim_idx = paddr[IDX_W+1:2];

    // Control fields
    wire trigger_source_select   = ctrl_q[calib_pkg::CTRL_TRIG_SEL];
    wire background_calib_enable = ctrl_q[calib_pkg::CTRL_BG_EN];
    wire fg_offset_enable        = ctrl_q[calib_pkg::CTRL_FG_OS];
    wire bg_offset_calib_option  = ctrl_q[calib_pkg::CTRL_BG_OS];
    wire low_power_bg_enable     = ctrl_q[calib_pkg::CTRL_LOW_POWER_BG_ENABLE];
    wire low_power_switch_select = ctrl_q[calib_pkg::CTRL_LP_SW_SEL];
    wire single_channel          = ctrl_q[calib_pkg::CTRL_SINGLE_CH];
    wire input_b_sel             = ctrl_q[calib_pkg::CTRL_INPUT_B];

    // Background starts only with the software source selected and its bit set
    wire bg_run = background_calib_enable & ~trigger_source_select & sw_calib_trigger_bit;
    // A rising trigger while background is wanted starts background, not foreground
    wire fg_req = trig_rise & ~bg_run;

    wire [31:0] status_word = {24'h0, fg_done_q, spare_q, victim_q, 1'b0, state_q};
    wire [31:0] rd_mux = hit_ctrl   ? {24'h0, ctrl_q} :
                         hit_soft   ? {31'h0, sw_calib_trigger_bit} :
                         hit_status ? status_word :
                         hit_timing ? {wake_len_q, sleep_len_q} :
                         hit_trim   ? {24'h0, trim_rd} : 32'h0;

    // Pass bookkeeping
    wire offset_on  = (state_q == calib_pkg::ST_FG_CAL) ? fg_offset_enable
                                                        : bg_offset_calib_option;
    wire step_end   = (step_cnt_q == calib_pkg::CAL_STEP_CYCLES - 16'h0001);
    wire phase_last = (phase_q == calib_pkg::PH_OFFSET) ||
                      ((phase_q == calib_pkg::PH_GAIN) && !offset_on);
    wire pass_end   = step_end & phase_last & bank_q;
    wire fg_last    = pass_end & (core_q == LAST_CORE);
    wire settle_end = (step_cnt_q == calib_pkg::SWAP_SETTLE - 16'h0001);
    wire sleep_end  = low_power_switch_select ? trig_rise
                                              : (step_cnt_q == sleep_len_q);
    wire wake_end   = (step_cnt_q == wake_len_q);

    // Pin passes two flops; the software bit is already on this clock
    trig_edge i_trig (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (hw_calib_trigger_pin),
        .sync_src (~trigger_source_select),
        .local_in (sw_calib_trigger_bit),
        .rise     (trig_rise)
    );

    // Entries 0-1 trim per input, 2-7 per bank
    trim_bank #(
        .N (calib_pkg::NUM_TRIMS),
        .W (calib_pkg::TRIM_W)
    ) i_trim (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .factory_val (factory_trim),
        .wr_en       (trim_wr),
        .idx         (trim_idx),
        .wr_data     (pwdata[calib_pkg::TRIM_W-1:0]),
        .rd_data     (trim_rd),
        .trim_out    (trim_out)
    );

    always_comb begin
        state_d    = state_q;
        phase_d    = phase_q;
        step_cnt_d = step_cnt_q + 16'h0001;
        core_d     = core_q;
        bank_d     = bank_q;
        spare_d    = spare_q;
        slot_a_d   = slot_a_q;
        slot_b_d   = slot_b_q;
        victim_d   = victim_q;
        unique case (state_q)
            calib_pkg::ST_IDLE: begin
                step_cnt_d = 16'h0000;
                if (fg_req) begin
                    state_d = calib_pkg::ST_FG_CAL;
                    phase_d = calib_pkg::PH_LIN;
                    core_d  = 2'd0;
                    bank_d  = 1'b0;
                end else if (bg_run) begin
                    state_d = calib_pkg::ST_BG_CAL;
                    phase_d = calib_pkg::PH_LIN;
                    core_d  = spare_q;
                    bank_d  = 1'b0;
                end
            end
            calib_pkg::ST_FG_CAL, calib_pkg::ST_BG_CAL: begin
                if (step_end) begin
                    step_cnt_d = 16'h0000;
                    if (!phase_last) begin
                        phase_d = (phase_q == calib_pkg::PH_LIN) ? calib_pkg::PH_GAIN
                                                                 : calib_pkg::PH_OFFSET;
                    end else begin
                        phase_d = calib_pkg::PH_LIN;
                        bank_d  = ~bank_q;
                    end
                end
                if (pass_end && state_q == calib_pkg::ST_FG_CAL) begin
                    if (fg_last) begin
                        state_d = calib_pkg::ST_IDLE;
                    end else begin
                        core_d = core_q + 2'd1;
                    end
                end else if (pass_end) begin
                    // Fresh core relieves the victim slot, which goes off-line
                    state_d  = calib_pkg::ST_BG_SWAP;
                    victim_d = ~victim_q;
                    if (victim_q) begin
                        slot_b_d = spare_q;
                        spare_d  = slot_b_q;
                    end else begin
                        slot_a_d = spare_q;
                        spare_d  = slot_a_q;
                    end
                end
            end
            calib_pkg::ST_BG_SWAP: begin
                // Hold a few cycles so the swap glitch settles before more work
                if (settle_end) begin
                    step_cnt_d = 16'h0000;
                    if (low_power_bg_enable) begin
                        state_d = calib_pkg::ST_BG_SLEEP;
                    end else begin
                        state_d = calib_pkg::ST_BG_CAL;
                        core_d  = spare_q;
                        phase_d = calib_pkg::PH_LIN;
                        bank_d  = 1'b0;
                    end
                end
            end
            calib_pkg::ST_BG_SLEEP: begin
                if (sleep_end) begin
                    step_cnt_d = 16'h0000;
                    state_d    = calib_pkg::ST_BG_WAKE;
                end
            end
            calib_pkg::ST_BG_WAKE: begin
                if (wake_end) begin
                    step_cnt_d = 16'h0000;
                    state_d    = calib_pkg::ST_BG_CAL;
                    core_d     = spare_q;
                    phase_d    = calib_pkg::PH_LIN;
                    bank_d     = 1'b0;
                end
            end
            default: begin
                state_d = calib_pkg::ST_IDLE;
            end
        endcase
        if (in_bg(state_q) && !background_calib_enable) begin
            state_d = calib_pkg::ST_IDLE;
        end
    end

    // Power-up lands directly in foreground calibration
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q    <= calib_pkg::ST_FG_CAL;
            phase_q    <= calib_pkg::PH_LIN;
            step_cnt_q <= 16'h0000;
            core_q     <= 2'd0;
            bank_q     <= 1'b0;
            spare_q    <= 2'd2;
            slot_a_q   <= 2'd0;
            slot_b_q   <= 2'd1;
            victim_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            phase_q    <= phase_d;
            step_cnt_q <= step_cnt_d;
            core_q     <= core_d;
            bank_q     <= bank_d;
            spare_q    <= spare_d;
            slot_a_q   <= slot_a_d;
            slot_b_q   <= slot_b_d;
            victim_q   <= victim_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fg_done_q <= 1'b0;
        end else if (state_q == calib_pkg::ST_IDLE && fg_req) begin
            fg_done_q <= 1'b0;
        end else if (state_q == calib_pkg::ST_FG_CAL && fg_last) begin
            fg_done_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q               <= calib_pkg::CTRL_RESET;
            sw_calib_trigger_bit <= 1'b0;
            sleep_len_q          <= calib_pkg::SLEEP_RESET;
            wake_len_q           <= calib_pkg::WAKE_RESET;
        end else if (wr_commit) begin
            if (hit_ctrl) ctrl_q <= pwdata[7:0];
            if (hit_soft) sw_calib_trigger_bit <= pwdata[0];
            if (hit_timing) sleep_len_q <= pwdata[15:0];
            if (hit_timing) wake_len_q <= pwdata[31:16];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= apb_access;
            pslverr_q <= apb_access & ~hit_any;
            if (apb_access && !pwrite) prdata_q <= rd_mux;
        end
    end

    // Routing of inputs to cores, slots to cores, and per-core power
    wire [1:0] input_sel = {1'b0, input_b_sel};
    assign map_d = {single_channel ? input_sel : 2'b00,
                    single_channel ? input_sel : 2'b01,
                    slot_a_q,
                    slot_b_q,
                    (state_q == calib_pkg::ST_BG_SLEEP) ? ~core_onehot(spare_q)
                                                        : 3'b111,
                    BANK_PHASE};

    // Outputs hold mid-code for the whole foreground pass
    wire fg_hold = (state_q == calib_pkg::ST_FG_CAL);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sample_a_q     <= calib_pkg::MID_CODE;
            sample_b_q     <= calib_pkg::MID_CODE;
            core_map_q     <= {2'b00, 2'b01, 2'd0, 2'd1, 3'b111, BANK_PHASE};
            cal_core_sel_q <= 3'b000;
            cal_ref_en_q   <= 1'b0;
            input_mute_q   <= 1'b0;
        end else begin
            sample_a_q     <= fg_hold ? calib_pkg::MID_CODE : slot_a_raw;
            sample_b_q     <= fg_hold ? calib_pkg::MID_CODE : slot_b_raw;
            core_map_q     <= map_d;
            cal_core_sel_q <= in_cal(state_q) ? core_onehot(core_q) : 3'b000;
            cal_ref_en_q   <= in_cal(state_q);
            input_mute_q   <= in_cal(state_q) && (phase_q == calib_pkg::PH_OFFSET);
        end
    end

    assign sample_a     = sample_a_q;
    assign sample_b     = sample_b_q;
    assign core_map     = core_map_q;
    assign cal_core_sel = cal_core_sel_q;
    assign cal_phase    = phase_q;
    assign cal_ref_en   = cal_ref_en_q;
    assign input_mute   = input_mute_q;
    assign fg_done      = fg_done_q;
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence fg_trigger_s;
        (state_q == calib_pkg::ST_IDLE) && fg_req;
    endsequence

    sequence fg_entered_s;
        (state_q == calib_pkg::ST_FG_CAL) && !fg_done;
    endsequence

    sequence bg_pass_s;
        (state_q == calib_pkg::ST_BG_CAL) && pass_end && background_calib_enable;
    endsequence

    fg_start_a: assert property (fg_trigger_s |=> fg_entered_s)
        else $error("foreground pass did not start on a trigger");
    mid_code_a: assert property ((state_q == calib_pkg::ST_FG_CAL) |=>
        (sample_a == calib_pkg::MID_CODE) && (sample_b == calib_pkg::MID_CODE))
        else $error("output left mid-code during foreground pass");
    bg_flow_a: assert property (in_bg(state_q) |=>
        (sample_a == $past(slot_a_raw)) && (sample_b == $past(slot_b_raw)))
        else $error("data stopped during background calibration");
    busy_ignore_a: assert property ((fg_hold && !fg_last) |=> fg_hold)
        else $error("foreground pass cut short");
    swap_turn_a: assert property (bg_pass_s |=> (state_q == calib_pkg::ST_BG_SWAP) &&
        (spare_q == ($past(victim_q) ? $past(slot_b_q) : $past(slot_a_q))))
        else $error("relieved core did not go off-line");
    slot_split_a: assert property (core_map.slot_a_core != core_map.slot_b_core)
        else $error("both slots served by one core");
    sleep_power_a: assert property ((state_q == calib_pkg::ST_BG_SLEEP) |=>
        ((core_map.core_power & core_onehot($past(spare_q))) == 3'b000))
        else $error("sleeping core left powered");
    offset_mute_a: assert property
        ((in_cal(state_q) && (phase_q == calib_pkg::PH_OFFSET)) |=> input_mute)
        else $error("offset step without quiet input");
endmodule

// *** testbench/host_trig_model.sv ***
// Host model that pulses the calibration trigger pin
`timescale 1ns/1ps
module host_trig_model (
    input  wire logic core_clk, // Core clock
    input  wire logic fire,     // Request a pin trigger
    output logic      trig_pin  // Trigger pin level
);
    initial trig_pin = 1'b0;
    always @(posedge core_clk) trig_pin <= fire;
endmodule

// *** testbench/adc_core_calibration_control_tb.sv ***
// Self-checking bench for the calibration controller
`timescale 1ns/1ps
module adc_core_calibration_control_tb;
    logic core_clk, rst_n, psel, penable, pwrite, fire, pin, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] fuse;
    logic [11:0] sa, sb;
    int failures, n_compared;
    adc_core_calibration_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .hw_calib_trigger_pin(pin), .factory_trim(fuse),
        .slot_a_raw(12'h5a5), .slot_b_raw(12'h3c3), .sample_a(sa), .sample_b(sb),
        .core_map(), .cal_core_sel(), .cal_phase(), .cal_ref_en(), .input_mute(),
        .trim_out(), .fg_done());
    host_trig_model i_host (.core_clk(core_clk), .fire(fire), .trig_pin(pin));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Holds the request until pready is sampled high, as the bus demands
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin failures++; complete_run(); end
        // Let the release edge pass so a following call never re-drives psel at once
        @(posedge core_clk);
    endtask
    task automatic wait_done();
        int n;
        for (n = 0; n < 40000 && i_dut.fg_done !== 1'b1; n++) @(posedge core_clk);
        chk({31'h0, i_dut.fg_done}, 32'h1);
        if (n >= 40000) complete_run();
    endtask
    task automatic power_up();
        repeat (3) @(posedge core_clk);
        chk({20'h0, sa}, {20'h0, calib_pkg::MID_CODE});
        chk({20'h0, sb}, {20'h0, calib_pkg::MID_CODE});
        wait_done();
    endtask
    task automatic trims();
        apb(1'b0, calib_pkg::ADDR_TRIM_BASE + 12'h004, 32'h0);
        chk(rd & 32'hff, {24'h0, fuse[15:8]});
        apb(1'b1, calib_pkg::ADDR_TRIM_BASE + 12'h004, 32'h0000_00c3);
        apb(1'b0, calib_pkg::ADDR_TRIM_BASE + 12'h004, 32'h0);
        chk(rd & 32'hff, 32'h0000_00c3);
        chk({24'h0, i_dut.trim_out[15:8]}, 32'h0000_00c3);
    endtask
    // Pin source chosen with the offset option set first; the pin restarts foreground
    task automatic pin_trigger();
        apb(1'b1, calib_pkg::ADDR_CTRL, 32'h0000_0005);
        fire <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk({31'h0, i_dut.fg_done}, 32'h0);
        chk({20'h0, sa}, {20'h0, calib_pkg::MID_CODE});
        fire <= 1'b0;
        wait_done();
    endtask
    // Inputs hold constants, so no offset option is needed in background
    task automatic background();
        apb(1'b1, calib_pkg::ADDR_CTRL, 32'h0000_0002);
        apb(1'b1, calib_pkg::ADDR_SOFT_TRIG, 32'h0000_0001);
        repeat (20) @(posedge core_clk);
        chk({20'h0, sa}, 32'h0000_05a5);
        chk({20'h0, sb}, 32'h0000_03c3);
        repeat (1100) @(posedge core_clk);
        apb(1'b0, calib_pkg::ADDR_STATUS, 32'h0);
        chk((rd >> 5) & 32'h3, 32'h0);
        chk({20'h0, sa}, 32'h0000_05a5);
        apb(1'b1, calib_pkg::ADDR_CTRL, 32'h0000_0000);
    endtask
    initial begin
        failures = 0; n_compared = 0;
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; fire = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; fuse = 64'h8877_6655_4433_2211;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        power_up();
        trims();
        pin_trigger();
        background();
        complete_run();
    end
endmodule
